// ### hdl/dptr_defines.svh
// Constants for the dual data pointer unit
// Contract
// RULE1 - Two independent 16-bit pointers, pointer_zero and pointer_one.
// RULE2 - pointer_select 0 picks pointer_zero, 1 picks pointer_one.
// RULE3 - Selected pointer is read and written at 82H low, 83H high.
// RULE4 - Unselected pointer is read and written at D4H low, D5H high.
// RULE5 - Changing pointer_select swaps the register pair mapping, contents unchanged.
// RULE6 - aux_control_one bit 2 reads zero, ignores writes; increment toggles select.
// RULE7 - Prefix opcode 0A5H inverts pointer_select for the next instruction only.
// RULE8 - Indirect jump ignores the prefix, always uses pointer_select.
// RULE9 - Load, increment, MOVC, MOVX use selected pointer; inverted forms use other.
// RULE10 - Decrement bit per pointer turns its increment into decrement.
// RULE11 - Decrement bits also set direction of automatic post-access updates.
// RULE12 - With update bit set, MOVC and MOVX adjust the used pointer by one.
// RULE13 - Software clears pointer_config before calling flash routines.
// RULE14 - Interrupt code saves and restores pointers and pointer modes.
// RULE15 - pointer_select is bit 0 of aux_control_one at A2H, resets 0.
// RULE16 - pointer_config lives at A1H, implemented bits reset to zero.
// RULE17 - Pointer steps wrap modulo 65536, no flags, no side effects.
// RULE18 - Each update bit governs only its own pointer, when that pointer is used.
`ifndef DPTR_DEFINES_SVH
`define DPTR_DEFINES_SVH

`define PTR_W 16
`define SFR_SEL_LO 8'h82
`define SFR_SEL_HI 8'h83
`define SFR_ALT_LO 8'hd4
`define SFR_ALT_HI 8'hd5
`define SFR_AUX1 8'ha2
`define SFR_PCFG 8'ha1
`define PREFIX_OPCODE 8'ha5

`define AUX1_SEL_BIT 0
`define AUX1_ZERO_BIT 2
`define AUX1_RESET 8'h00
`define AUX1_KEEP_MASK 8'hf9

`define PCFG_DEC0_BIT 4
`define PCFG_DEC1_BIT 5
`define PCFG_UPD0_BIT 6
`define PCFG_UPD1_BIT 7
`define PCFG_RESET 8'h00
`define PCFG_KEEP_MASK 8'hf0

`endif

// ### hdl/dptr_pkg.sv
// Types shared by the dual data pointer unit
package dptr_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_LOAD = 3'b001,
    OP_INC = 3'b010,
    OP_MOVC = 3'b011,
    OP_MOVX = 3'b100,
    OP_JMP = 3'b101
  } ptr_op_t;
endpackage

// ### hdl/dual_data_pointer_unit.sv
// Dual data pointer unit: two pointers, select, prefix and auto-update
`timescale 1ns/10ps
`include "dptr_defines.svh"
module dual_data_pointer_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_ff,
  output logic sfr_hit_ff,
  // Opcode fetch from the decoder
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  // Instruction execute from the datapath
  input wire dptr_pkg::ptr_op_t op,
  input wire logic [15:0] op_imm,
  // Access address toward memory
  output logic [15:0] access_addr_ff,
  output logic access_valid_ff,
  output dptr_pkg::ptr_op_t access_op_ff,
  // Mode state
  output logic select_ff,
  output logic prefix_ff
);
  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] aux_ff;
  logic [7:0] pcfg_ff;
  logic nxt_prefix;

  wire wr_aux = sfr_wr && (sfr_addr == `SFR_AUX1);
  wire wr_pcfg = sfr_wr && (sfr_addr == `SFR_PCFG);
  wire sel = aux_ff[`AUX1_SEL_BIT];
  wire [1:0] dec = {pcfg_ff[`PCFG_DEC1_BIT], pcfg_ff[`PCFG_DEC0_BIT]};
  wire [1:0] upd = {pcfg_ff[`PCFG_UPD1_BIT], pcfg_ff[`PCFG_UPD0_BIT]};

  // Bit 2 and bit 1 are never stored, so an increment of the whole register
  // can only toggle the select bit and never carries upward
  always_ff @(posedge clk) begin
    if (rst) begin
      aux_ff <= `AUX1_RESET; // RULE15
    end else if (wr_aux) begin
      aux_ff <= sfr_wdata & `AUX1_KEEP_MASK; // RULE6
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pcfg_ff <= `PCFG_RESET; // RULE16
    end else if (wr_pcfg) begin
      pcfg_ff <= sfr_wdata & `PCFG_KEEP_MASK;
    end
  end

  // ****************************************
  // Prefix tracking
  // ****************************************
  // The prefix lives from its own fetch to the end of the next instruction
  always_comb begin
    nxt_prefix = prefix_ff;
    if (op != dptr_pkg::OP_NONE) begin
      nxt_prefix = 1'b0;
    end
    if (fetch_valid) begin
      nxt_prefix = (fetch_byte == `PREFIX_OPCODE); // RULE7
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prefix_ff <= 1'b0;
    end else begin
      prefix_ff <= nxt_prefix;
    end
  end

  // ****************************************
  // Instruction routing
  // ****************************************
  logic target;
  logic step;
  logic down;
  logic load;

  ptr_route u_route (
    .op(op),
    .prefix(prefix_ff),
    .sel(sel),
    .dec(dec),
    .upd(upd),
    .target(target),
    .step(step),
    .down(down),
    .load(load)
  );

  // ****************************************
  // Pointer slots
  // ****************************************
  ptr_slot_if sif [2] ();
  logic [15:0] val [2];

  // Slot i sits at the selected pair when i equals the select bit
  wire wr_sel_lo = sfr_wr && (sfr_addr == `SFR_SEL_LO);
  wire wr_sel_hi = sfr_wr && (sfr_addr == `SFR_SEL_HI);
  wire wr_alt_lo = sfr_wr && (sfr_addr == `SFR_ALT_LO);
  wire wr_alt_hi = sfr_wr && (sfr_addr == `SFR_ALT_HI);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_slot
      wire is_sel = (sel == 1'(gi));
      wire is_tgt = (target == 1'(gi));
      assign sif[gi].wr_lo = is_sel ? wr_sel_lo : wr_alt_lo; // RULE3 RULE4 RULE5
      assign sif[gi].wr_hi = is_sel ? wr_sel_hi : wr_alt_hi; // RULE3 RULE4 RULE5
      assign sif[gi].wdata = sfr_wdata;
      assign sif[gi].load = load && is_tgt; // RULE9
      assign sif[gi].load_val = op_imm;
      assign sif[gi].step = step && is_tgt; // RULE12 RULE18
      assign sif[gi].down = down;
      assign val[gi] = sif[gi].value;
      ptr_slot #(
        .W(`PTR_W)
      ) u_slot (
        .clk(clk),
        .rst(rst),
        .s(sif[gi])
      );
    end
  endgenerate

  wire [15:0] sel_val = val[sel];
  wire [15:0] alt_val = val[~sel];

  // ****************************************
  // Register read port
  // ****************************************
  logic [7:0] rd_mux;
  logic rd_hit;

  always_comb begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    case (sfr_addr)
      `SFR_SEL_LO: rd_mux = sel_val[7:0]; // RULE3
      `SFR_SEL_HI: rd_mux = sel_val[15:8]; // RULE3
      `SFR_ALT_LO: rd_mux = alt_val[7:0]; // RULE4
      `SFR_ALT_HI: rd_mux = alt_val[15:8]; // RULE4
      `SFR_AUX1: rd_mux = aux_ff; // RULE6
      `SFR_PCFG: rd_mux = pcfg_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata_ff <= 8'h00;
      sfr_hit_ff <= 1'b0;
    end else begin
      sfr_rdata_ff <= rd_mux;
      sfr_hit_ff <= rd_hit;
    end
  end

  // ****************************************
  // Access address toward memory
  // ****************************************
  // The address is the pointer value before any post-update
  wire is_addr_op = (op == dptr_pkg::OP_MOVC) || (op == dptr_pkg::OP_MOVX) || (op == dptr_pkg::OP_JMP);
  wire nxt_sel_out = wr_aux ? sfr_wdata[`AUX1_SEL_BIT] : sel;

  always_ff @(posedge clk) begin
    if (rst) begin
      access_addr_ff <= 16'h0000;
      access_valid_ff <= 1'b0;
      access_op_ff <= dptr_pkg::OP_NONE;
      select_ff <= 1'b0;
    end else begin
      access_addr_ff <= is_addr_op ? val[target] : access_addr_ff; // RULE8 RULE9
      access_valid_ff <= is_addr_op;
      access_op_ff <= is_addr_op ? op : dptr_pkg::OP_NONE;
      select_ff <= nxt_sel_out;
    end
  end

endmodule

// ### hdl/ptr_route.sv
// Picks the pointer an instruction acts on and how it moves
`timescale 1ns/10ps
module ptr_route (
  // Instruction
  input wire dptr_pkg::ptr_op_t op,
  input wire logic prefix,
  // Mode
  input wire logic sel,
  input wire logic [1:0] dec,
  input wire logic [1:0] upd,
  // Result
  output logic target,
  output logic step,
  output logic down,
  output logic load
);
  wire is_access = (op == dptr_pkg::OP_MOVC) || (op == dptr_pkg::OP_MOVX);

  assign target = (op == dptr_pkg::OP_JMP) ? sel : (sel ^ prefix); // RULE7 RULE8 RULE9 RULE2
  assign load = (op == dptr_pkg::OP_LOAD); // RULE9
  assign step = (op == dptr_pkg::OP_INC) || (is_access && upd[target]); // RULE12 RULE18
  assign down = dec[target]; // RULE10 RULE11
endmodule

// ### hdl/ptr_slot.sv
// One pointer register with byte writes, load and step
`timescale 1ns/10ps
`include "dptr_defines.svh"
module ptr_slot #(
  parameter int W = `PTR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  ptr_slot_if.slot s
);
  logic [W-1:0] ptr_ff;
  logic [W-1:0] nxt_ptr;
  wire [W-1:0] stepped = s.down ? ptr_ff - W'(1) : ptr_ff + W'(1); // RULE17

  // Byte writes from the register port win over an instruction in the same cycle
  always_comb begin
    nxt_ptr = ptr_ff;
    if (s.load) begin
      nxt_ptr = s.load_val[W-1:0];
    end else if (s.step) begin
      nxt_ptr = stepped; // RULE10 RULE11
    end
    if (s.wr_lo) begin
      nxt_ptr[7:0] = s.wdata;
    end
    if (s.wr_hi) begin
      nxt_ptr[W-1:8] = s.wdata[W-9:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_ff <= '0;
    end else begin
      ptr_ff <= nxt_ptr; // RULE1
    end
  end

  assign s.value = 16'(ptr_ff);
endmodule

// ### hdl/ptr_slot_if.sv
// Control and value bundle between the unit and one pointer slot
`timescale 1ns/10ps
interface ptr_slot_if;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  logic load;
  logic [15:0] load_val;
  logic step;
  logic down;
  logic [15:0] value;
  modport owner (output wr_lo, output wr_hi, output wdata, output load, output load_val,
                 output step, output down, input value);
  modport slot (input wr_lo, input wr_hi, input wdata, input load, input load_val,
                input step, input down, output value);
endinterface

// ### tb/cpu_model.sv
// Decoder model that fetches prefix bytes and issues pointer instructions
`timescale 1ns/10ps
module cpu_model (
  // Clock
  input wire logic clk,
  // Toward the unit
  output logic fetch_valid,
  output logic [7:0] fetch_byte,
  output dptr_pkg::ptr_op_t op,
  output logic [15:0] op_imm
);
  initial begin
    fetch_valid = 1'b0;
    fetch_byte = 8'h5a;
    op = dptr_pkg::OP_NONE;
    op_imm = 16'h0000;
  end
  // Prefix goes out in the cycle just before the instruction it modifies
  task automatic exec(input logic pre, input dptr_pkg::ptr_op_t o, input logic [15:0] imm);
    if (pre) begin
      fetch_valid = 1'b1;
      fetch_byte = 8'ha5;
      @(posedge clk);
      #1;
      fetch_valid = 1'b0;
      fetch_byte = 8'h5a;
    end
    op = o;
    op_imm = imm;
    @(posedge clk);
    #1;
    op = dptr_pkg::OP_NONE;
    // Immediate is stale once taken, so show its inverse
    op_imm = ~imm;
  endtask
endmodule

// ### tb/dptr_props.sv
// Port assertions for the dual data pointer unit
`timescale 1ns/10ps
module dptr_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_rdata_ff,
  input wire logic sfr_hit_ff,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  input wire dptr_pkg::ptr_op_t op,
  input wire logic [15:0] access_addr_ff,
  input wire logic access_valid_ff,
  input wire dptr_pkg::ptr_op_t access_op_ff,
  input wire logic select_ff,
  input wire logic prefix_ff
);
  wire logic mapped = sfr_addr inside {8'h82, 8'h83, 8'hd4, 8'hd5, 8'ha1, 8'ha2};
  wire logic acc = op inside {dptr_pkg::OP_MOVC, dptr_pkg::OP_MOVX, dptr_pkg::OP_JMP};
  wire logic aux_wr = sfr_wr && sfr_addr == 8'ha2;
  wire logic pfx = fetch_valid && fetch_byte == 8'ha5;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_HIT: assert property (1 |=> sfr_hit_ff == $past(mapped)) else $error("hit flag wrong");
  AST_UNMAPPED: assert property (!mapped |=> sfr_rdata_ff == 8'h00) else $error("unmapped data");
  AST_ACC: assert property (acc |=> access_valid_ff && access_op_ff == $past(op)) else $error("no access");
  AST_NOACC: assert property (!acc |=> !access_valid_ff && $stable(access_addr_ff)) else $error("stray access");
  AST_PRE_SET: assert property (pfx |=> prefix_ff) else $error("prefix lost");
  AST_PRE_CLR: assert property (op != dptr_pkg::OP_NONE && !fetch_valid |=> !prefix_ff) else $error("prefix kept");
  AST_SEL: assert property (!aux_wr ##1 !aux_wr |=> $stable(select_ff)) else $error("select moved");
  AST_AUX: assert property (sfr_addr == 8'ha2 |=> sfr_rdata_ff[2:1] == 2'b00) else $error("aux bits");
  AST_CFG: assert property (sfr_addr == 8'ha1 |=> sfr_rdata_ff[3:0] == 4'h0) else $error("cfg bits");
  CV_PRE_INC: cover property (pfx ##1 op == dptr_pkg::OP_INC);
  CV_PRE_JMP: cover property (pfx ##1 op == dptr_pkg::OP_JMP);
  CV_AUX: cover property (aux_wr ##2 select_ff);
endmodule
bind dual_data_pointer_unit dptr_props props (
  .clk(clk),
  .rst(rst),
  .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr),
  .sfr_rdata_ff(sfr_rdata_ff),
  .sfr_hit_ff(sfr_hit_ff),
  .fetch_valid(fetch_valid),
  .fetch_byte(fetch_byte),
  .op(op),
  .access_addr_ff(access_addr_ff),
  .access_valid_ff(access_valid_ff),
  .access_op_ff(access_op_ff),
  .select_ff(select_ff),
  .prefix_ff(prefix_ff)
);

// ### tb/tb.sv
// Self-checking bench for the dual data pointer unit
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata_ff, fetch_byte;
  logic sfr_hit_ff, fetch_valid, access_valid_ff, select_ff, prefix_ff;
  logic [15:0] op_imm, access_addr_ff;
  dptr_pkg::ptr_op_t op, access_op_ff;
  logic [15:0] p [2];
  logic sel;
  logic [7:0] cfg;
  logic [15:0] sp [2];
  logic ssel;
  logic [7:0] scfg;
  int fails = 0;
  int compares = 0;
  int seed = 72;
  int i, r;
  always #5 clk = ~clk;
  cpu_model cpu (
    .clk(clk),
    .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte),
    .op(op),
    .op_imm(op_imm)
  );
  dual_data_pointer_unit dut (
    .clk(clk),
    .rst(rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata_ff(sfr_rdata_ff),
    .sfr_hit_ff(sfr_hit_ff),
    .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte),
    .op(op),
    .op_imm(op_imm),
    .access_addr_ff(access_addr_ff),
    .access_valid_ff(access_valid_ff),
    .access_op_ff(access_op_ff),
    .select_ff(select_ff),
    .prefix_ff(prefix_ff)
  );
  function automatic logic [15:0] step_val(input logic [15:0] v, input logic d);
    return d ? v - 16'h0001 : v + 16'h0001;
  endfunction
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    sfr_wdata = ~v;
    // Quiet edge so a following write never re-raises the strobe in the same time step
    @(posedge clk);
    #1;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [8:0] exp);
    sfr_addr = a;
    @(posedge clk);
    #1;
    check(n, {sfr_hit_ff, sfr_rdata_ff}, exp);
  endtask
  task automatic chk_ptrs();
    rdc("sel_lo", 8'h82, {1'b1, p[sel][7:0]});
    rdc("sel_hi", 8'h83, {1'b1, p[sel][15:8]});
    rdc("alt_lo", 8'hd4, {1'b1, p[!sel][7:0]});
    rdc("alt_hi", 8'hd5, {1'b1, p[!sel][15:8]});
    check("select", select_ff, sel);
  endtask
  task automatic wp(input int k, input logic [7:0] v);
    logic w;
    w = k[1] ? !sel : sel;
    wr(k[1] ? 8'hd4 + k[0] : 8'h82 + k[0], v);
    if (k[0]) p[w][15:8] = v;
    else p[w][7:0] = v;
  endtask
  // Extra cycle lets the select mirror settle before the next instruction
  task automatic sw(input logic b);
    wr(8'ha2, {7'h00, b});
    sel = b;
    @(posedge clk);
    #1;
    chk_ptrs();
  endtask
  task automatic wc(input logic [7:0] v);
    wr(8'ha1, v);
    cfg = v & 8'hf0;
  endtask
  task automatic do_op(input logic pre, input dptr_pkg::ptr_op_t o, input logic [15:0] imm);
    logic t;
    logic [15:0] old;
    t = (o == dptr_pkg::OP_JMP) ? sel : sel ^ pre;
    old = p[t];
    cpu.exec(pre, o, imm);
    if (o == dptr_pkg::OP_LOAD) p[t] = imm;
    if (o == dptr_pkg::OP_INC || (o inside {dptr_pkg::OP_MOVC, dptr_pkg::OP_MOVX} && cfg[6 + t]))
      p[t] = step_val(old, cfg[4 + t]);
    if (o inside {dptr_pkg::OP_MOVC, dptr_pkg::OP_MOVX, dptr_pkg::OP_JMP}) begin
      check("acc_addr", access_addr_ff, old);
      check("acc_op", {access_valid_ff, access_op_ff}, {1'b1, o});
    end
    check("prefix", prefix_ff, 1'b0);
    chk_ptrs();
  endtask
  initial begin
    p[0] = 16'h0000;
    p[1] = 16'h0000;
    sel = 1'b0;
    cfg = 8'h00;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    rdc("cfg", 8'ha1, 9'h100);
    rdc("aux", 8'ha2, 9'h100);
    rdc("unmapped", 8'h55, 9'h000);
    chk_ptrs();
    wr(8'ha2, 8'hff);
    rdc("aux_ff", 8'ha2, 9'h1f9);
    wr(8'ha2, 8'hfa);
    rdc("aux_inc", 8'ha2, 9'h1f8);
    sw(1'b0);
    $display("test reset and aux done");
    wp(0, 8'hff);
    wp(1, 8'hff);
    do_op(1'b0, dptr_pkg::OP_INC, 16'h0000);
    wc(8'h10);
    do_op(1'b1, dptr_pkg::OP_INC, 16'h0000);
    do_op(1'b0, dptr_pkg::OP_INC, 16'h0000);
    wc(8'hf0);
    for (i = 1; i < 6; i++) do_op(1'b1, dptr_pkg::ptr_op_t'(3'(i)), 16'h8001);
    $display("test corners done");
    for (i = 0; i < 300; i++) begin
      r = {$random(seed)} % 4;
      if (r == 0) wp({$random(seed)} % 4, 8'($random(seed)));
      else if (r == 1) sw(1'($random(seed)));
      else if (r == 2) wc(8'($random(seed)));
      else do_op(1'($random(seed)), dptr_pkg::ptr_op_t'(3'(1 + {$random(seed)} % 5)), 16'($random(seed)));
    end
    $display("test random done");
    // Handler-style context swap: save pointers and modes, disturb them, put them back
    sp = p;
    ssel = sel;
    scfg = cfg;
    sw(!ssel);
    wc(8'h3c);
    do_op(1'b0, dptr_pkg::OP_LOAD, 16'h1234);
    do_op(1'b1, dptr_pkg::OP_MOVX, 16'h0000);
    sw(ssel);
    wc(scfg);
    wp(0, sp[ssel][7:0]);
    wp(1, sp[ssel][15:8]);
    wp(2, sp[!ssel][7:0]);
    wp(3, sp[!ssel][15:8]);
    chk_ptrs();
    rdc("cfg_back", 8'ha1, {1'b1, scfg});
    $display("test context restore done");
    wc(8'h00);
    rdc("cfg_clear", 8'ha1, 9'h100);
    test_done();
  end
  initial begin
    #1000000;
    fails++;
    test_done();
  end
endmodule
